// ==== common/prc_pkg.sv ====
package prc_pkg;
	// ------------------------------------------------------------
	// register map (word aligned byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FILT_TC = 8'h04;
	localparam logic [7:0] ADDR_WINDOW = 8'h08;
	localparam logic [7:0] ADDR_SETTLE = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
	localparam logic [7:0] ADDR_POS_ERR = 8'h1C;
	localparam logic [7:0] ADDR_FEEDBACK = 8'h20;
	// ------------------------------------------------------------
	// ctrl and irq bit fields
	// ------------------------------------------------------------
	localparam int CTRL_FORM_BIT = 0;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_ALLOC_LSB = 8;
	localparam int CTRL_SPEED_BIT = 12;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_LEAVE_BIT = 1;
	localparam int IRQ_INH_BIT = 2;
	// ------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------
	localparam logic FORM_RST = 1'b0;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [3:0] MODE_INHIBIT = 4'hB;
	localparam logic [1:0] ALLOC_RST = 2'h0;
	localparam logic [14:0] FILT_TC_RST = 15'h0000;
	localparam logic [12:0] WINDOW_RST = 13'h000A;
	localparam logic [15:0] SETTLE_RST = 16'h01F4;
	localparam int OUT_TERMINALS = 4;
	// ------------------------------------------------------------
	// timing: 0.1 ms tick at 125 MHz
	// ------------------------------------------------------------
	localparam int CLK_HZ = 125000000;
	localparam int TICK_US = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
	localparam int POS_W = 32;
endpackage : prc_pkg

// ==== hw/smooth_stage.sv ====
`timescale 1ns/10ps
// smoothing of a signed pulse stream: output pulses track an exponential
// (first order) or cascaded (second order) lag of the accumulated input.
// total count is preserved except on flush, which drops pending output: output only emits while target != emitted.
module smooth_stage (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic tick,
	input wire logic second_order,
	input wire logic [14:0] tc,
	input wire logic in_up,
	input wire logic in_dn,
	input wire logic flush,
	output logic out_up,
	output logic out_dn
);
	logic signed [31:0] cmd_r, cmd_nxt;
	logic signed [47:0] s1_r, s1_nxt, s2_r, s2_nxt;
	logic signed [31:0] emit_r, emit_nxt;
	logic signed [31:0] target;
	logic signed [47:0] d1, d2;

	// ------------------------------------------------------------
	// filter state, 16 fraction bits
	// ------------------------------------------------------------
	always_comb begin
		cmd_nxt = cmd_r + 32'(in_up) - 32'(in_dn);
		d1 = ($signed({cmd_r, 16'h0000}) - s1_r) / $signed({33'h0, tc});
		d2 = (s1_r - s2_r) / $signed({33'h0, tc});
		s1_nxt = s1_r;
		s2_nxt = s2_r;
		if (flush || tc == 15'h0000) begin
			s1_nxt = {cmd_nxt, 16'h0000};
			s2_nxt = {cmd_nxt, 16'h0000};
		end else if (tick) begin
			s1_nxt = (d1 == 48'sh0 && s1_r != {cmd_r, 16'h0000}) ? {cmd_r, 16'h0000} : s1_r + d1;
			s2_nxt = (d2 == 48'sh0 && s2_r != s1_r) ? s1_r : s2_r + d2;
		end
		// zero time constant: straight through, no delay
		target = (tc == 15'h0000) ? cmd_nxt : (second_order ? s2_r[47:16] : s1_r[47:16]);
		out_up = 1'b0;
		out_dn = 1'b0;
		emit_nxt = emit_r;
		if (flush) begin
			emit_nxt = cmd_nxt;
		end else if (target > emit_r) begin
			out_up = 1'b1;
			emit_nxt = emit_r + 32'sd1;
		end else if (target < emit_r) begin
			out_dn = 1'b1;
			emit_nxt = emit_r - 32'sd1;
		end
		// every input pulse is emitted once unless a flush drops it first
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cmd_r <= '0;
			s1_r <= '0;
			s2_r <= '0;
			emit_r <= '0;
		end else if (ce) begin
			cmd_r <= cmd_nxt;
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			emit_r <= emit_nxt;
		end
	end
endmodule : smooth_stage

// ==== hw/position_reference_conditioner.sv ====
`timescale 1ns/10ps
// How it works
// - filter form 0 gives first-order smoothing, 1 gives second-order.
// - a new filter form only takes effect after restart.
// - filter time constant 0 to 32767 in 0.1 ms steps, default 0.
// - smoothing keeps the total reference pulse count, but pulses still pending at a position error clear are dropped.
// - a new filter time constant applies after a new reference and position error clear.
// - done output low when positioning finished, high while in progress.
// - done only while error is below window, range 0 to 5000, default 10.
// - error must stay in window longer than settle time, default 500 ticks.
// - in speed control the allocated terminal carries the speed match indication.
// - the done indication can be routed to another output terminal.
// - while inhibited, reference pulses are ignored and not counted.
// - inhibit exists only with control mode B, latched at restart.
module position_reference_conditioner (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic ref_up,
	input wire logic ref_dn,
	input wire logic mode_switch_n,
	input wire logic position_error_clear,
	input wire logic fb_up,
	input wire logic fb_dn,
	input wire logic speed_match_indication,
	output logic cmd_up,
	output logic cmd_dn,
	output logic [3:0] out_terminal_n,
	output logic positioning_done_n,
	output logic irq
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] sync0_r, sync1_r;
	logic [NSYNC-1:0] pins;
	logic up_s, dn_s, inh_pin_n, clr_s, fbu_s, fbd_s, spd_s;
	logic up_d_r, dn_d_r, clr_d_r;
	logic up_edge, dn_edge, clr_edge;

	assign pins = {speed_match_indication, fb_dn, fb_up, position_error_clear, mode_switch_n, ref_dn, ref_up};
	assign {spd_s, fbd_s, fbu_s, clr_s, inh_pin_n, dn_s, up_s} = sync1_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			// mode switch idles high, so no false inhibit after reset
			sync0_r <= 7'h04;
			sync1_r <= 7'h04;
			up_d_r <= 1'b0;
			dn_d_r <= 1'b0;
			clr_d_r <= 1'b0;
		end else if (ce) begin
			sync0_r <= pins;
			sync1_r <= sync0_r;
			up_d_r <= up_s;
			dn_d_r <= dn_s;
			clr_d_r <= clr_s;
		end
	end

	assign up_edge = up_s && !up_d_r;
	assign dn_edge = dn_s && !dn_d_r;
	assign clr_edge = clr_s && !clr_d_r;

	// ------------------------------------------------------------
	// settings registers
	// ------------------------------------------------------------
	// form and mode settings keep their value through reset, so a restart picks them up
	logic form_sw_r = prc_pkg::FORM_RST;
	logic form_sw_nxt, form_act_r;
	logic [3:0] mode_sw_r = prc_pkg::MODE_RST;
	logic [3:0] mode_sw_nxt, mode_act_r;
	logic [1:0] alloc_r, alloc_nxt;
	logic speed_mode_r, speed_mode_nxt;
	logic [14:0] tc_sw_r, tc_sw_nxt, tc_act_r, tc_act_nxt;
	logic [12:0] window_r, window_nxt;
	logic [15:0] settle_r, settle_nxt;
	logic [2:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
	logic started_r;
	logic new_ref_r, new_ref_nxt;
	logic wr, rd;
	logic [31:0] rdata;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr[7:2] == off[7:2]);
	endfunction : hit

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

	// ------------------------------------------------------------
	// pulse gating, inhibit, tick
	// ------------------------------------------------------------
	logic inhibit;
	logic gated_up, gated_dn;
	logic [13:0] tick_cnt_r, tick_cnt_nxt;
	logic tick;

	// inhibit only in mode B, pin low stops counting
	assign inhibit = (mode_act_r == prc_pkg::MODE_INHIBIT) && !inh_pin_n;
	assign gated_up = up_edge && !inhibit;
	assign gated_dn = dn_edge && !inhibit;
	assign tick = (tick_cnt_r == 14'(prc_pkg::TICK_CYCLES - 1));

	always_comb begin
		tick_cnt_nxt = tick ? 14'h0000 : tick_cnt_r + 14'h0001;
	end

	// ------------------------------------------------------------
	// smoothing
	// ------------------------------------------------------------
	smooth_stage u_smooth (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.tick(tick),
		.second_order(form_act_r),
		.tc(tc_act_r),
		.in_up(gated_up),
		.in_dn(gated_dn),
		.flush(clr_edge),
		.out_up(cmd_up),
		.out_dn(cmd_dn)
	);

	// ------------------------------------------------------------
	// position error and completion
	// ------------------------------------------------------------
	logic signed [31:0] err_r, err_nxt;
	logic signed [31:0] fbk_r, fbk_nxt;
	logic [31:0] err_abs;
	logic in_window;
	logic [15:0] settle_cnt_r, settle_cnt_nxt;
	logic done_r, done_nxt;
	logic [3:0] term_nxt;
	logic [3:0] term_r;

	assign err_abs = err_r[31] ? 32'(-err_r) : 32'(err_r);
	assign in_window = err_abs < {19'h0, window_r};

	always_comb begin
		err_nxt = err_r + 32'(cmd_up) - 32'(cmd_dn) - 32'(fbu_s) + 32'(fbd_s);
		fbk_nxt = fbk_r + 32'(fbu_s) - 32'(fbd_s);
		if (clr_edge) begin
			err_nxt = '0;
		end
		settle_cnt_nxt = settle_cnt_r;
		done_nxt = done_r;
		if (!in_window || clr_edge) begin
			settle_cnt_nxt = '0;
			done_nxt = 1'b0;
		end else if (settle_cnt_r > settle_r) begin
			done_nxt = 1'b1;
		end else if (tick) begin
			settle_cnt_nxt = settle_cnt_r + 16'h0001;
		end
		term_nxt = 4'hF;
		// speed match replaces done in speed mode, routed by allocation
		term_nxt[alloc_r] = speed_mode_r ? !spd_s : !done_r;
	end

	assign out_terminal_n = term_r;
	assign positioning_done_n = !done_r;
	assign irq = |(irq_stat_r & irq_mask_r);

	// ------------------------------------------------------------
	// register writes and events
	// ------------------------------------------------------------
	always_comb begin
		form_sw_nxt = form_sw_r;
		mode_sw_nxt = mode_sw_r;
		alloc_nxt = alloc_r;
		speed_mode_nxt = speed_mode_r;
		tc_sw_nxt = tc_sw_r;
		window_nxt = window_r;
		settle_nxt = settle_r;
		irq_mask_nxt = irq_mask_r;
		irq_stat_nxt = irq_stat_r;
		new_ref_nxt = new_ref_r;
		tc_act_nxt = tc_act_r;
		if (wr && hit(wb_adr_i, prc_pkg::ADDR_CTRL)) begin
			form_sw_nxt = wb_dat_i[prc_pkg::CTRL_FORM_BIT];
			mode_sw_nxt = wb_dat_i[prc_pkg::CTRL_MODE_LSB +: 4];
		end
		if (wr && hit(wb_adr_i, prc_pkg::ADDR_CTRL) && wb_sel_i[1]) begin
			alloc_nxt = wb_dat_i[prc_pkg::CTRL_ALLOC_LSB +: 2];
			speed_mode_nxt = wb_dat_i[prc_pkg::CTRL_SPEED_BIT];
		end
		if (wr && hit(wb_adr_i, prc_pkg::ADDR_FILT_TC) && wb_sel_i[1]) begin
			tc_sw_nxt = wb_dat_i[14:0];
		end
		if (wr && hit(wb_adr_i, prc_pkg::ADDR_WINDOW) && wb_sel_i[1]) begin
			window_nxt = wb_dat_i[12:0];
		end
		if (wr && hit(wb_adr_i, prc_pkg::ADDR_SETTLE) && wb_sel_i[1]) begin
			settle_nxt = wb_dat_i[15:0];
		end
		if (wr && hit(wb_adr_i, prc_pkg::ADDR_IRQ_MASK)) begin
			irq_mask_nxt = wb_dat_i[2:0];
		end
		if (wr && hit(wb_adr_i, prc_pkg::ADDR_IRQ_STAT)) begin
			irq_stat_nxt = irq_stat_r & ~wb_dat_i[2:0];
		end
		// events set after the clear so a set wins
		if (done_nxt && !done_r) begin
			irq_stat_nxt[prc_pkg::IRQ_DONE_BIT] = 1'b1;
		end
		if (done_r && !in_window) begin
			irq_stat_nxt[prc_pkg::IRQ_LEAVE_BIT] = 1'b1;
		end
		if (inhibit && (up_edge || dn_edge)) begin
			irq_stat_nxt[prc_pkg::IRQ_INH_BIT] = 1'b1;
		end
		// new time constant waits for a new reference then a clear
		if (gated_up || gated_dn) begin
			new_ref_nxt = 1'b1;
		end
		if (clr_edge && new_ref_r) begin
			tc_act_nxt = tc_sw_r;
			new_ref_nxt = 1'b0;
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		if (hit(wb_adr_i, prc_pkg::ADDR_CTRL)) begin
			rdata = {19'h0, speed_mode_r, 1'b0, 1'b0, alloc_r, mode_sw_r, 3'h0, form_sw_r};
		end else if (hit(wb_adr_i, prc_pkg::ADDR_FILT_TC)) begin
			rdata = {17'h0, tc_sw_r};
		end else if (hit(wb_adr_i, prc_pkg::ADDR_WINDOW)) begin
			rdata = {19'h0, window_r};
		end else if (hit(wb_adr_i, prc_pkg::ADDR_SETTLE)) begin
			rdata = {16'h0, settle_r};
		end else if (hit(wb_adr_i, prc_pkg::ADDR_STATUS)) begin
			rdata = {24'h0, inhibit, form_act_r, mode_act_r == prc_pkg::MODE_INHIBIT, in_window, 3'h0, done_r};
		end else if (hit(wb_adr_i, prc_pkg::ADDR_IRQ_STAT)) begin
			rdata = {29'h0, irq_stat_r};
		end else if (hit(wb_adr_i, prc_pkg::ADDR_IRQ_MASK)) begin
			rdata = {29'h0, irq_mask_r};
		end else if (hit(wb_adr_i, prc_pkg::ADDR_POS_ERR)) begin
			rdata = err_r;
		end else if (hit(wb_adr_i, prc_pkg::ADDR_FEEDBACK)) begin
			rdata = fbk_r;
		end
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			alloc_r <= prc_pkg::ALLOC_RST;
			speed_mode_r <= 1'b0;
			tc_sw_r <= prc_pkg::FILT_TC_RST;
			tc_act_r <= prc_pkg::FILT_TC_RST;
			window_r <= prc_pkg::WINDOW_RST;
			settle_r <= prc_pkg::SETTLE_RST;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			new_ref_r <= 1'b0;
			tick_cnt_r <= '0;
			err_r <= '0;
			fbk_r <= '0;
			settle_cnt_r <= '0;
			done_r <= 1'b0;
			term_r <= 4'hF;
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			started_r <= 1'b0;
			form_act_r <= form_sw_r;
			mode_act_r <= mode_sw_r;
		end else if (ce) begin
			form_sw_r <= form_sw_nxt;
			mode_sw_r <= mode_sw_nxt;
			alloc_r <= alloc_nxt;
			speed_mode_r <= speed_mode_nxt;
			tc_sw_r <= tc_sw_nxt;
			tc_act_r <= tc_act_nxt;
			window_r <= window_nxt;
			settle_r <= settle_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			new_ref_r <= new_ref_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			err_r <= err_nxt;
			fbk_r <= fbk_nxt;
			settle_cnt_r <= settle_cnt_nxt;
			done_r <= done_nxt;
			term_r <= term_nxt;
			wb_ack_o <= wr || rd;
			wb_dat_o <= rd ? rdata : wb_dat_o;
			// form and mode load during reset and once more at the first enabled edge after reset
			started_r <= 1'b1;
			if (!started_r) begin
				form_act_r <= form_sw_r;
				mode_act_r <= mode_sw_r;
			end
		end
	end
endmodule : position_reference_conditioner

// ==== tb/prc_sva.sv ====
`timescale 1ns/10ps
module prc_sva (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic position_error_clear,
	input wire logic cmd_up,
	input wire logic cmd_dn,
	input wire logic [3:0] out_terminal_n,
	input wire logic positioning_done_n,
	input wire logic irq
);
	// holds while the settle time setting is at least one tick
	localparam int SETTLE_MIN = prc_pkg::TICK_CYCLES - 2;
	int hi_cnt;
	always_ff @(posedge clk) begin
		if (!resetn || !positioning_done_n) begin
			hi_cnt <= 0;
		end else begin
			hi_cnt <= hi_cnt + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_clear;
		$rose(position_error_clear);
	endsequence
	sequence s_settled;
		$fell(positioning_done_n);
	endsequence
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
	property p_ack_cause;
		wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_hold;
		$changed(wb_dat_o) |-> wb_ack_o;
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved outside ack");
	property p_cmd_excl;
		!(cmd_up && cmd_dn);
	endproperty
	a_cmd_excl: assert property (p_cmd_excl) else $error("both command pulses");
	property p_one_term;
		$countones(~out_terminal_n) <= 1;
	endproperty
	a_one_term: assert property (p_one_term) else $error("several terminals active");
	property p_reset_vals;
		$rose(resetn) |-> positioning_done_n && out_terminal_n == 4'hF && !irq && !wb_ack_o;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("outputs not idle after reset");
	property p_clear_drop;
		s_clear |-> ##[1:4] positioning_done_n;
	endproperty
	a_clear_drop: assert property (p_clear_drop) else $error("done kept over clear");
	property p_settle_min;
		s_settled |-> hi_cnt >= SETTLE_MIN;
	endproperty
	a_settle_min: assert property (p_settle_min) else $error("done before settle time");
endmodule : prc_sva
bind position_reference_conditioner prc_sva chk_i (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .position_error_clear(position_error_clear),
	.cmd_up(cmd_up), .cmd_dn(cmd_dn), .out_terminal_n(out_terminal_n),
	.positioning_done_n(positioning_done_n), .irq(irq));

// ==== tb/host_model.sv ====
`timescale 1ns/10ps
module host_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] n_req,
	input wire logic dir_dn,
	input wire logic follow,
	input wire logic stop_req,
	input wire logic cmd_up,
	input wire logic cmd_dn,
	output logic busy,
	output logic ref_up,
	output logic ref_dn,
	output logic fb_up,
	output logic fb_dn,
	output logic mode_switch_n
);
	logic [7:0] left_r = 8'h00;
	logic [2:0] ph_r = 3'h0;
	logic dn_r = 1'b0;
	// pulses are four cycles high, four low
	assign busy = left_r != 8'h00;
	assign ref_up = busy && !dn_r && !ph_r[2];
	assign ref_dn = busy && dn_r && !ph_r[2];
	assign mode_switch_n = !stop_req;
	// motor follows the smoothed command one pulse per command pulse
	always @(posedge clk) begin
		fb_up <= follow && cmd_up;
		fb_dn <= follow && cmd_dn;
		if (go) begin
			left_r <= n_req;
			dn_r <= dir_dn;
			ph_r <= 3'h0;
		end else if (busy) begin
			ph_r <= ph_r + 3'h1;
			if (ph_r == 3'h7) begin
				left_r <= left_r - 8'h01;
			end
		end
	end
endmodule : host_model

// ==== tb/position_reference_conditioner_tb.sv ====
`timescale 1ns/10ps
module position_reference_conditioner_tb;
	logic clk, resetn, we, cyc, stb, ack, clr, go, dir_dn, follow, stop_req, busy, speed_in;
	logic ref_up, ref_dn, fb_up, fb_dn, msw_n, cmd_up, cmd_dn, done_n, irq;
	logic [7:0] adr, n_req;
	logic [31:0] wdat, dat_o, rdat;
	logic [3:0] term_n;
	int failures, n_compared, cyc_n, cmd_cnt, base;
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	position_reference_conditioner uut (.clk(clk), .resetn(resetn), .ce(1'b1), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
		.ref_up(ref_up), .ref_dn(ref_dn), .mode_switch_n(msw_n), .position_error_clear(clr), .fb_up(fb_up),
		.fb_dn(fb_dn), .speed_match_indication(speed_in), .cmd_up(cmd_up), .cmd_dn(cmd_dn),
		.out_terminal_n(term_n), .positioning_done_n(done_n), .irq(irq));
	host_model host (.clk(clk), .go(go), .n_req(n_req), .dir_dn(dir_dn), .follow(follow), .stop_req(stop_req),
		.cmd_up(cmd_up), .cmd_dn(cmd_dn), .busy(busy), .ref_up(ref_up), .ref_dn(ref_dn), .fb_up(fb_up),
		.fb_dn(fb_dn), .mode_switch_n(msw_n));
	always @(posedge clk) begin
		cmd_cnt <= cmd_cnt + (cmd_up === 1'b1) - (cmd_dn === 1'b1);
		cyc_n <= cyc_n + 1;
		if (cyc_n == 70000) begin
			failures++;
			wrap_up();
		end
	end
	task wrap_up;
		if (failures == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0);
		chk(what, exp, rdat);
	endtask : rd
	task pulses(input logic [7:0] n, input logic dn, input logic fol);
		@(posedge clk);
		n_req <= n;
		dir_dn <= dn;
		follow <= fol;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (busy);
		repeat (8) @(posedge clk);
	endtask : pulses
	task clear_err;
		@(posedge clk);
		clr <= 1'b1;
		repeat (4) @(posedge clk);
		clr <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : clear_err
	task t_reset_vals;
		rd(prc_pkg::ADDR_CTRL, 32'h0, "ctrl");
		rd(prc_pkg::ADDR_FILT_TC, 32'h0, "filter_time_constant");
		rd(prc_pkg::ADDR_WINDOW, 32'hA, "completion_error_window");
		rd(prc_pkg::ADDR_SETTLE, 32'h1F4, "completion_settle_time");
		rd(8'h40, 32'h0, "unmapped");
		chk("done_n", 32'h1, {31'h0, done_n});
	endtask : t_reset_vals
	task t_terminals;
		wb(1'b1, prc_pkg::ADDR_CTRL, 32'h1200);
		speed_in <= 1'b1;
		repeat (6) @(posedge clk);
		chk("term speed on", 32'hB, {28'h0, term_n});
		speed_in <= 1'b0;
		repeat (6) @(posedge clk);
		chk("term speed off", 32'hF, {28'h0, term_n});
		wb(1'b1, prc_pkg::ADDR_CTRL, 32'h2B1);
		rd(prc_pkg::ADDR_STATUS, 32'h10, "active form mode");
		stop_req <= 1'b1;
		base = cmd_cnt;
		pulses(8'h02, 1'b0, 1'b1);
		chk("count unlatched inhibit", 32'h2, cmd_cnt - base);
		stop_req <= 1'b0;
		wb(1'b1, prc_pkg::ADDR_CTRL, 32'h200);
	endtask : t_terminals
	task t_settle;
		wb(1'b1, prc_pkg::ADDR_SETTLE, 32'h1);
		clear_err();
		base = cmd_cnt;
		pulses(8'h05, 1'b0, 1'b1);
		chk("unfiltered count", 32'h5, cmd_cnt - base);
		repeat (12000) @(posedge clk);
		chk("done early", 32'h1, {31'h0, done_n});
		for (int i = 0; i < 30000 && done_n !== 1'b0; i++) @(posedge clk);
		chk("done settled", 32'h0, {31'h0, done_n});
		@(posedge clk);
		chk("term alloc", 32'hB, {28'h0, term_n});
	endtask : t_settle
	task t_leave;
		rd(prc_pkg::ADDR_IRQ_STAT, 32'h1, "irq stat done");
		base = cmd_cnt;
		pulses(8'h14, 1'b0, 1'b0);
		chk("done left", 32'h1, {31'h0, done_n});
		rd(prc_pkg::ADDR_IRQ_STAT, 32'h3, "irq stat left");
		chk("irq masked", 32'h0, {31'h0, irq});
		wb(1'b1, prc_pkg::ADDR_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		wb(1'b1, prc_pkg::ADDR_IRQ_STAT, 32'h2);
		rd(prc_pkg::ADDR_IRQ_STAT, 32'h1, "irq stat cleared");
		chk("irq cleared", 32'h0, {31'h0, irq});
		pulses(8'h14, 1'b1, 1'b0);
		chk("count back", 32'h0, cmd_cnt - base);
	endtask : t_leave
	task t_filter;
		wb(1'b1, prc_pkg::ADDR_FILT_TC, 32'h1);
		base = cmd_cnt;
		pulses(8'h03, 1'b0, 1'b1);
		chk("tc pending", 32'h3, cmd_cnt - base);
		clear_err();
		base = cmd_cnt;
		pulses(8'h08, 1'b0, 1'b1);
		chk("tc applied", 32'h1, {31'h0, cmd_cnt - base < 8});
		for (int i = 0; i < 50000 && cmd_cnt - base < 8; i++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk("filtered count", 32'h8, cmd_cnt - base);
	endtask : t_filter
	task t_restart;
		wb(1'b1, prc_pkg::ADDR_CTRL, 32'hB1);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		rd(prc_pkg::ADDR_STATUS, 32'h70, "restart form mode");
		stop_req <= 1'b1;
		base = cmd_cnt;
		pulses(8'h02, 1'b0, 1'b1);
		chk("count inhibited", 32'h0, cmd_cnt - base);
		rd(prc_pkg::ADDR_IRQ_STAT, 32'h4, "irq stat inhibit");
		stop_req <= 1'b0;
		pulses(8'h02, 1'b0, 1'b1);
		chk("count resumed", 32'h2, cmd_cnt - base);
	endtask : t_restart
	initial begin
		{resetn, we, cyc, stb, clr, go, dir_dn, follow, stop_req, speed_in} = '0;
		{adr, n_req, wdat} = '0;
		{failures, n_compared, cyc_n, cmd_cnt} = '0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		t_reset_vals();
		t_terminals();
		t_settle();
		t_leave();
		t_filter();
		t_restart();
		wrap_up();
	end
endmodule : position_reference_conditioner_tb
